// ---- src/lcdx_pkg.sv ----
// lcdx_pkg: constants, opcode patterns, register map and bus carriers for
// the extended-instruction decoder of a graphic character display.
// assumes: one 250 MHz clock, synchronous active-low reset.
package lcdx_pkg;

   // clock
   localparam int unsigned CLK_PERIOD_NS = 4;

   // axi4-lite carriers (8-bit byte address, 32-bit data)
   localparam int unsigned AXIL_AW = 8;
   localparam int unsigned AXIL_DW = 32;

   typedef struct packed {
      logic               awvalid;
      logic [AXIL_AW-1:0] awaddr;
      logic               wvalid;
      logic [AXIL_DW-1:0] wdata;
      logic [3:0]         wstrb;
      logic               bready;
      logic               arvalid;
      logic [AXIL_AW-1:0] araddr;
      logic               rready;
   } lcdx_axil_req_t;

   typedef struct packed {
      logic               awready;
      logic               wready;
      logic               bvalid;
      logic [1:0]         bresp;
      logic               arready;
      logic               rvalid;
      logic [AXIL_DW-1:0] rdata;
      logic [1:0]         rresp;
   } lcdx_axil_rsp_t;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // register offsets
   localparam logic [AXIL_AW-1:0] REG_CMD    = 8'h00;
   localparam logic [AXIL_AW-1:0] REG_STATUS = 8'h04;
   localparam logic [AXIL_AW-1:0] REG_GADDR  = 8'h08;
   localparam logic [AXIL_AW-1:0] REG_SCROLL = 8'h0C;

   // field positions
   localparam int unsigned CMD_DATA_BIT  = 8;
   localparam int unsigned ST_BUSY_BIT   = 0;
   localparam int unsigned ST_STBY_BIT   = 1;
   localparam int unsigned ST_EXT_BIT    = 2;
   localparam int unsigned ST_SSEL_BIT   = 3;
   localparam int unsigned ST_GFX_BIT    = 4;
   localparam int unsigned ST_BW_BIT     = 5;
   localparam int unsigned ST_REV_LSB    = 6;
   localparam int unsigned ST_LSEL_LSB   = 10;
   localparam int unsigned ST_DROP_BIT   = 12;
   localparam int unsigned GA_HORZ_LSB   = 8;
   localparam int unsigned GA_VPEND_BIT  = 16;
   localparam int unsigned GA_VALID_BIT  = 17;
   localparam int unsigned GA_HALF_BIT   = 18;
   localparam int unsigned SC_GLYPH_LSB  = 8;

   // reset values
   localparam logic       RST_BW   = 1'b1;
   localparam logic       RST_EXT  = 1'b0;
   localparam logic       RST_GFX  = 1'b0;
   localparam logic       RST_SSEL = 1'b0;
   localparam logic [1:0] RST_LSEL = 2'h0;

   // opcodes and field limits
   localparam logic [7:0] OP_STANDBY   = 8'h01;
   localparam logic [3:0] HORZ_MAX     = 4'hF;
   localparam logic [3:0] HORZ_WRAP    = 4'h0;
   localparam int unsigned BUSY_CYCLES_DEF = 16;

   typedef enum logic [3:0] {
      OPC_NONE, OPC_STANDBY, OPC_SSEL, OPC_REVERSE, OPC_FUNC,
      OPC_SCROLL, OPC_GLYPH, OPC_GADDR, OPC_BASIC
   } lcdx_opc_t;

endpackage

// ---- src/lcdx_axil_slave.sv ----
// lcdx_axil_slave: single-outstanding axi4-lite slave front end.
// assumes: the parent decodes the address combinationally and answers
// wr_err, rd_data and rd_err in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module lcdx_axil_slave (
   input  wire logic                   aclk,     // clock
   input  wire logic                   aresetn,  // sync reset, low
   input  wire lcdx_pkg::lcdx_axil_req_t req,    // master to slave
   output lcdx_pkg::lcdx_axil_rsp_t    rsp,      // slave to master
   output logic                        wr_en,    // one-cycle write pulse
   output logic [7:0]                  wr_addr,  // write byte address
   output logic [31:0]                 wr_data,  // write data
   output logic [3:0]                  wr_strb,  // write byte enables
   input  wire logic                   wr_err,   // write address unmapped
   output logic [7:0]                  rd_addr,  // read byte address
   input  wire logic [31:0]            rd_data,  // read data
   input  wire logic                   rd_err    // read address unmapped
);
   import lcdx_pkg::*;

   logic        aw_full_q, aw_full_d, w_full_q, w_full_d;
   logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
   logic [7:0]  awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
   logic [3:0]  wstrb_q, wstrb_d;
   logic        aw_hs, w_hs, ar_hs;

   // write fires in the first cycle both halves are held, so the order of
   // address and data never matters
   always_comb begin
      aw_hs     = req.awvalid & ~aw_full_q & ~bvalid_q;
      w_hs      = req.wvalid & ~w_full_q & ~bvalid_q;
      ar_hs     = req.arvalid & ~rvalid_q;
      wr_en     = aw_full_q & w_full_q & ~bvalid_q;
      aw_full_d = wr_en ? 1'b0 : (aw_full_q | aw_hs);
      w_full_d  = wr_en ? 1'b0 : (w_full_q | w_hs);
      awaddr_d  = aw_hs ? req.awaddr : awaddr_q;
      wdata_d   = w_hs ? req.wdata : wdata_q;
      wstrb_d   = w_hs ? req.wstrb : wstrb_q;
      bvalid_d  = wr_en | (bvalid_q & ~req.bready);
      bresp_d   = wr_en ? (wr_err ? RESP_SLVERR : RESP_OKAY) : bresp_q;
      rvalid_d  = ar_hs | (rvalid_q & ~req.rready);
      rdata_d   = ar_hs ? rd_data : rdata_q;
      rresp_d   = ar_hs ? (rd_err ? RESP_SLVERR : RESP_OKAY) : rresp_q;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         rvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
         rresp_q   <= RESP_OKAY;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h0000_0000;
         rdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
      end else begin
         aw_full_q <= aw_full_d;
         w_full_q  <= w_full_d;
         bvalid_q  <= bvalid_d;
         rvalid_q  <= rvalid_d;
         bresp_q   <= bresp_d;
         rresp_q   <= rresp_d;
         awaddr_q  <= awaddr_d;
         wdata_q   <= wdata_d;
         rdata_q   <= rdata_d;
         wstrb_q   <= wstrb_d;
      end
   end

   assign wr_addr     = awaddr_q;
   assign wr_data     = wdata_q;
   assign wr_strb     = wstrb_q;
   assign rd_addr     = req.araddr;
   assign rsp.awready = ~aw_full_q & ~bvalid_q;
   assign rsp.wready  = ~w_full_q & ~bvalid_q;
   assign rsp.bvalid  = bvalid_q;
   assign rsp.bresp   = bresp_q;
   assign rsp.arready = ~rvalid_q;
   assign rsp.rvalid  = rvalid_q;
   assign rsp.rdata   = rdata_q;
   assign rsp.rresp   = rresp_q;

endmodule // lcdx_axil_slave
`default_nettype wire

// ---- src/lcdx_gaddr.sv ----
// lcdx_gaddr: graphic address counter, 6-bit vertical, 4-bit horizontal.
// assumes: load and increment strobes come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module lcdx_gaddr (
   input  wire logic       aclk,     // clock
   input  wire logic       aresetn,  // sync reset, low
   input  wire logic       load_v,   // load vertical part
   input  wire logic       load_h,   // load horizontal part
   input  wire logic [5:0] din,      // address bits from the opcode
   input  wire logic       inc,      // advance after a full word
   output logic [5:0]      vert,     // vertical address
   output logic [3:0]      horz      // horizontal address
);
   import lcdx_pkg::*;

   logic [5:0] vert_q, vert_d;
   logic [3:0] horz_q, horz_d;

   always_comb begin
      vert_d = vert_q;
      horz_d = horz_q;
      if (load_v) begin
         vert_d = din;
      end
      if (load_h) begin
         horz_d = din[3:0];
      end else if (inc) begin
         horz_d = (horz_q == HORZ_MAX) ? HORZ_WRAP : horz_q + 4'h1;
      end
      // no carry: vert_d untouched by inc
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         vert_q <= 6'h00;
         horz_q <= 4'h0;
      end else begin
         vert_q <= vert_d;
         horz_q <= horz_d;
      end
   end

   assign vert = vert_q;
   assign horz = horz_q;

endmodule // lcdx_gaddr
`default_nettype wire

// ---- src/lcdx_decoder.sv ----
// lcdx_decoder: extended instruction decoder of a graphic character display
// controller, reached by software over axi4-lite.
// assumes: one clock, sync active-low reset; the text and pixel memories
// sit outside and only see the strobes and latched modes driven here.
//
// Operation
// - Extended opcode 01h enters standby; any later instruction leaves it.
// - Standby entry or exit never touches text display memory.
// - Scroll/RAM select with flag 1 enables vertical scroll mode.
// - Flag 0 makes the 01xxxxxx opcode set the glyph memory address.
// - Reverse opcode line bits pick line one to four, 00 to 11.
// - Each reverse opcode toggles that line; first reverses, next restores.
// - Line-select bits of the reverse function reset to 00.
// - Extended function set bit 4 picks 8-bit bus when 1, 4-bit when 0.
// - Function set bit 2 picks extended set when 1, basic when 0.
// - Extended function set bit 1 turns graphics on or off.
// - With scroll selected, 01xxxxxx loads six-bit scroll displacement.
// - Graphic address takes two 10xxxxxx bytes: vertical then horizontal.
// - Vertical address six bits, horizontal four, second byte bits 5:4 zero.
// - After both are set, horizontal counter advances, 0Fh wraps to 00h.
// - Horizontal wrap never carries into the vertical address.
// - These opcodes decode only in the extended set; else basic meaning.
// - While busy, no instruction is accepted; host waits for not busy.
// - Memory words are two bytes; address advances after the second.
`timescale 1ns/1ps
`default_nettype none
module lcdx_decoder #(
   parameter int unsigned BUSY_CYCLES = lcdx_pkg::BUSY_CYCLES_DEF
) (
   input  wire logic                   aclk,          // 250 MHz clock
   input  wire logic                   aresetn,       // sync reset, low
   input  wire lcdx_pkg::lcdx_axil_req_t axil_req,    // register bus in
   output lcdx_pkg::lcdx_axil_rsp_t    axil_rsp,      // register bus out
   output logic                        busy_flag,     // instruction running
   output logic                        standby,       // standby mode
   output logic                        bus_width_sel, // 1: 8-bit host bus
   output logic                        ins_set_sel,   // 1: extended set
   output logic                        graphics_on,   // graphic display on
   output logic                        scroll_en,     // vertical scroll mode
   output logic [5:0]                  scroll_addr,   // scroll displacement
   output logic [5:0]                  glyph_addr,    // glyph memory address
   output logic [3:0]                  line_reverse,  // per-line reverse
   output logic                        pix_wr,        // pixel word write
   output logic [9:0]                  pix_addr,      // {vertical,horizontal}
   output logic [15:0]                 pix_data       // pixel word
);
   import lcdx_pkg::*;

   localparam int unsigned BCW = $clog2(BUSY_CYCLES + 1);

   initial begin
      if (BUSY_CYCLES < 1) begin
         $error("lcdx_decoder: BUSY_CYCLES must be at least 1");
      end
   end

   // set-dependent decode
   // opcode classes; the same byte means different things per set
   function automatic lcdx_opc_t decode_op(input logic [7:0] b,
                                           input logic       ext,
                                           input logic       ssel);
      decode_op = OPC_BASIC;
      if (b[7:5] == 3'h1 && (!ext || !b[0])) begin
         decode_op = OPC_FUNC;
      end else if (!ext) begin
         decode_op = (b[7:6] == 2'h1) ? OPC_GLYPH : OPC_BASIC;
      end else if (b == OP_STANDBY) begin
         decode_op = OPC_STANDBY;
      end else if (b[7:1] == 7'h01) begin
         decode_op = OPC_SSEL;
      end else if (b[7:2] == 6'h01) begin
         decode_op = OPC_REVERSE;
      end else if (b[7:6] == 2'h1) begin
         decode_op = ssel ? OPC_SCROLL : OPC_GLYPH;
      end else if (b[7:6] == 2'h2) begin
         decode_op = OPC_GADDR;
      end
   endfunction

   logic        wr_en, wr_err, rd_err;
   logic [7:0]  wr_addr, rd_addr;
   logic [31:0] wr_data, rd_data;
   logic [3:0]  wr_strb;

   lcdx_axil_slave u_bus (
      .aclk    (aclk),
      .aresetn (aresetn),
      .req     (axil_req),
      .rsp     (axil_rsp),
      .wr_en   (wr_en),
      .wr_addr (wr_addr),
      .wr_data (wr_data),
      .wr_strb (wr_strb),
      .wr_err  (wr_err),
      .rd_addr (rd_addr),
      .rd_data (rd_data),
      .rd_err  (rd_err)
   );

   // mode latches
   logic           stby_q, stby_d, bw_q, bw_d, ext_q, ext_d;
   logic           gfx_q, gfx_d, ssel_q, ssel_d, drop_q, drop_d;
   logic [1:0]     lsel_q, lsel_d;
   logic [3:0]     rev_q, rev_d;
   logic [5:0]     scr_q, scr_d, glyph_q, glyph_d;
   logic [8:0]     last_q, last_d;
   logic [BCW-1:0] bcnt_q, bcnt_d;
   // graphic sequencing
   logic           vpend_q, vpend_d, gvalid_q, gvalid_d;
   logic           half_q, half_d, pwr_q, pwr_d;
   logic [7:0]     hi_q, hi_d;
   logic [15:0]    pdat_q, pdat_d;
   logic [9:0]     paddr_q, paddr_d;
   // decode
   logic           cmd_wr, accept, is_data;
   logic [7:0]     byte_in;
   lcdx_opc_t      opc;
   logic           load_v, load_h, ginc;
   logic [5:0]     gvert;
   logic [3:0]     ghorz;

   assign cmd_wr  = wr_en && wr_addr == REG_CMD && wr_strb[0];
   assign byte_in = wr_data[7:0];
   assign is_data = wr_data[CMD_DATA_BIT];
   assign accept  = cmd_wr && bcnt_q == '0;
   assign opc     = (accept && !is_data) ?
                    decode_op(byte_in, ext_q, ssel_q) : OPC_NONE;

   always_comb begin
      stby_d  = stby_q;
      bw_d    = bw_q;
      ext_d   = ext_q;
      gfx_d   = gfx_q;
      ssel_d  = ssel_q;
      lsel_d  = lsel_q;
      rev_d   = rev_q;
      scr_d   = scr_q;
      glyph_d = glyph_q;
      last_d  = last_q;
      drop_d  = drop_q;
      bcnt_d  = (bcnt_q != '0) ? bcnt_q - 1'b1 : bcnt_q;
      if (cmd_wr && !accept) begin
         drop_d = 1'b1;
      end
      if (accept) begin
         last_d = wr_data[8:0];
         drop_d = 1'b0;
         bcnt_d = BCW'(BUSY_CYCLES);
         stby_d = 1'b0;
      end
      // modes change only on their own opcodes, except standby, which any accepted write clears
      case (opc)
         OPC_STANDBY: stby_d = 1'b1;
         OPC_SSEL:    ssel_d = byte_in[0];
         OPC_REVERSE: begin
            lsel_d = byte_in[1:0];
            rev_d[byte_in[1:0]] = ~rev_q[byte_in[1:0]];
         end
         OPC_FUNC: begin
            bw_d = byte_in[4];
            ext_d = byte_in[2];
            // graphics only in the extended form
            if (ext_q) begin
               gfx_d = byte_in[1];
            end
         end
         OPC_SCROLL:  scr_d = byte_in[5:0];
         OPC_GLYPH:   glyph_d = byte_in[5:0];
         default: begin
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stby_q  <= 1'b0;
         bw_q    <= RST_BW;
         ext_q   <= RST_EXT;
         gfx_q   <= RST_GFX;
         ssel_q  <= RST_SSEL;
         lsel_q  <= RST_LSEL;
         rev_q   <= 4'h0;
         scr_q   <= 6'h00;
         glyph_q <= 6'h00;
         last_q  <= 9'h000;
         drop_q  <= 1'b0;
         bcnt_q  <= '0;
      end else begin
         stby_q  <= stby_d;
         bw_q    <= bw_d;
         ext_q   <= ext_d;
         gfx_q   <= gfx_d;
         ssel_q  <= ssel_d;
         lsel_q  <= lsel_d;
         rev_q   <= rev_d;
         scr_q   <= scr_d;
         glyph_q <= glyph_d;
         last_q  <= last_d;
         drop_q  <= drop_d;
         bcnt_q  <= bcnt_d;
      end
   end

   // a stray instruction between the two address bytes cancels the pair,
   // so a half-set address is never used for pixel writes
   always_comb begin
      vpend_d  = vpend_q;
      gvalid_d = gvalid_q;
      half_d   = half_q;
      hi_d     = hi_q;
      pwr_d    = 1'b0;
      pdat_d   = pdat_q;
      paddr_d  = paddr_q;
      load_v   = 1'b0;
      load_h   = 1'b0;
      ginc     = 1'b0;
      if (accept && is_data) begin
         vpend_d = 1'b0;
         if (!half_q) begin
            hi_d   = byte_in;
            half_d = 1'b1;
         end else begin
            half_d = 1'b0;
            if (gvalid_q) begin
               pwr_d   = 1'b1;
               pdat_d  = {hi_q, byte_in};
               paddr_d = {gvert, ghorz};
               ginc    = 1'b1;
            end
         end
      end else if (opc == OPC_GADDR) begin
         if (!vpend_q) begin
            load_v   = 1'b1;
            vpend_d  = 1'b1;
            gvalid_d = 1'b0;
         end else begin
            load_h   = 1'b1;
            vpend_d  = 1'b0;
            gvalid_d = 1'b1;
            half_d   = 1'b0;
         end
      end else if (opc != OPC_NONE) begin
         vpend_d = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         vpend_q  <= 1'b0;
         gvalid_q <= 1'b0;
         half_q   <= 1'b0;
         hi_q     <= 8'h00;
         pwr_q    <= 1'b0;
         pdat_q   <= 16'h0000;
         paddr_q  <= 10'h000;
      end else begin
         vpend_q  <= vpend_d;
         gvalid_q <= gvalid_d;
         half_q   <= half_d;
         hi_q     <= hi_d;
         pwr_q    <= pwr_d;
         pdat_q   <= pdat_d;
         paddr_q  <= paddr_d;
      end
   end

   // second byte keeps only its low four bits
   lcdx_gaddr u_gaddr (
      .aclk    (aclk),
      .aresetn (aresetn),
      .load_v  (load_v),
      .load_h  (load_h),
      .din     (byte_in[5:0]),
      .inc     (ginc),
      .vert    (gvert),
      .horz    (ghorz)
   );

   // read map and address check
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_err  = 1'b0;
      case (rd_addr)
         REG_CMD:    rd_data[8:0] = last_q;
         REG_STATUS: begin
            rd_data[ST_BUSY_BIT] = bcnt_q != '0;
            rd_data[ST_STBY_BIT] = stby_q;
            rd_data[ST_EXT_BIT]  = ext_q;
            rd_data[ST_SSEL_BIT] = ssel_q;
            rd_data[ST_GFX_BIT]  = gfx_q;
            rd_data[ST_BW_BIT]   = bw_q;
            rd_data[ST_REV_LSB +: 4]  = rev_q;
            rd_data[ST_LSEL_LSB +: 2] = lsel_q;
            rd_data[ST_DROP_BIT] = drop_q;
         end
         REG_GADDR: begin
            rd_data[5:0]                = gvert;
            rd_data[GA_HORZ_LSB +: 4]   = ghorz;
            rd_data[GA_VPEND_BIT]       = vpend_q;
            rd_data[GA_VALID_BIT]       = gvalid_q;
            rd_data[GA_HALF_BIT]        = half_q;
         end
         REG_SCROLL: begin
            rd_data[5:0]              = scr_q;
            rd_data[SC_GLYPH_LSB +: 6] = glyph_q;
         end
         default: rd_err = 1'b1;
      endcase
   end

   assign wr_err = !(wr_addr == REG_CMD || wr_addr == REG_STATUS ||
                     wr_addr == REG_GADDR || wr_addr == REG_SCROLL);

   assign busy_flag     = bcnt_q != '0;
   assign standby       = stby_q;
   assign bus_width_sel = bw_q;
   assign ins_set_sel   = ext_q;
   assign graphics_on   = gfx_q;
   assign scroll_en     = ssel_q;
   assign scroll_addr   = scr_q;
   assign glyph_addr    = glyph_q;
   assign line_reverse  = rev_q;
   assign pix_wr        = pwr_q;
   assign pix_addr      = paddr_q;
   assign pix_data      = pdat_q;

endmodule // lcdx_decoder
`default_nettype wire

// ---- tb/lcdx_host.sv ----
// lcdx_host: host model, an axi4-lite master with command helpers.
// assumes: decoder answers on the same clock; bench owns the timeout.
`timescale 1ns/1ps
`default_nettype none
module lcdx_host (
   input  wire logic                     aclk, // clock
   output lcdx_pkg::lcdx_axil_req_t      req,  // master to decoder
   input  wire lcdx_pkg::lcdx_axil_rsp_t rsp   // decoder to master
);
   import lcdx_pkg::*;
   initial req = '0;

   task automatic xfer(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic [1:0] r);
      lcdx_axil_rsp_t s;
      logic           done;
      done = 1'b0;
      @(posedge aclk);
      if (wr) begin
         req.awvalid <= 1'b1;
         req.awaddr  <= a;
         req.wvalid  <= 1'b1;
         req.wdata   <= d;
         req.wstrb   <= 4'hF;
         req.bready  <= 1'b1;
      end else begin
         req.arvalid <= 1'b1;
         req.araddr  <= a;
         req.rready  <= 1'b1;
      end
      while (!done) begin
         // sample mid-cycle: ready is combinational, so read it settled
         @(negedge aclk);
         s = rsp;
         @(posedge aclk);
         if (s.awready) req.awvalid <= 1'b0;
         if (s.wready) req.wvalid <= 1'b0;
         if (s.arready) req.arvalid <= 1'b0;
         if (wr ? s.bvalid : s.rvalid) begin
            done = 1'b1;
            q = s.rdata;
            r = wr ? s.bresp : s.rresp;
            req.bready <= 1'b0;
            req.rready <= 1'b0;
         end
      end
   endtask

   task automatic cmd(input logic [8:0] b);
      logic [31:0] q;
      logic [1:0]  r;
      xfer(1'b1, REG_CMD, {23'h0, b}, q, r);
      do xfer(1'b0, REG_STATUS, '0, q, r);
      while (q[ST_BUSY_BIT] !== 1'b0);
   endtask
endmodule // lcdx_host
`default_nettype wire

// ---- tb/lcdx_decoder_props.sv ----
// lcdx_decoder_props: concurrent checks on the decoder's ports.
// assumes: bound to lcdx_decoder; one clock, sync active-low reset.
`timescale 1ns/1ps
`default_nettype none
module lcdx_decoder_props #(
   parameter int unsigned BUSY_CYCLES = 16
) (
   input wire logic                     aclk,         // clock
   input wire logic                     aresetn,      // sync reset, low
   input wire lcdx_pkg::lcdx_axil_req_t axil_req,     // bus in
   input wire lcdx_pkg::lcdx_axil_rsp_t axil_rsp,     // bus out
   input wire logic                     busy_flag,    // busy
   input wire logic                     standby,      // standby
   input wire logic                     ins_set_sel,  // extended set
   input wire logic                     scroll_en,    // scroll mode
   input wire logic [3:0]               line_reverse, // reversed lines
   input wire logic                     pix_wr        // pixel write
);
   import lcdx_pkg::*;
   logic [7:0] bcnt_q, bcnt_d;
   always_comb bcnt_d = busy_flag ? bcnt_q + 8'h01 : 8'h00;
   always_ff @(posedge aclk) bcnt_q <= aresetn ? bcnt_d : 8'h00;

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_wr_both;
      axil_req.awvalid && axil_rsp.awready && axil_req.wvalid
      && axil_rsp.wready;
   endsequence
   sequence s_accept;
      $rose(busy_flag);
   endsequence

   property p_busy_len; $fell(busy_flag) |-> bcnt_q == BUSY_CYCLES;
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("busy length wrong");
   property p_modes_hold; !$rose(busy_flag) |->
      $stable({standby, ins_set_sel, scroll_en, line_reverse}); endproperty
   a_modes_hold: assert property (p_modes_hold)
      else $error("mode changed without instruction");
   property p_rev_one; s_accept |->
      $countones(line_reverse ^ $past(line_reverse)) <= 1; endproperty
   a_rev_one: assert property (p_rev_one)
      else $error("more than one line toggled");
   property p_stby_ext; $rose(standby) |-> ins_set_sel; endproperty
   a_stby_ext: assert property (p_stby_ext)
      else $error("standby outside extended set");
   property p_pix_pulse; pix_wr |=> !pix_wr; endproperty
   a_pix_pulse: assert property (p_pix_pulse)
      else $error("pixel write longer than a cycle");
   property p_pix_busy; pix_wr |-> s_accept; endproperty
   a_pix_busy: assert property (p_pix_busy)
      else $error("pixel write without instruction");
   property p_wr_lat; s_wr_both |-> ##2 axil_rsp.bvalid; endproperty
   a_wr_lat: assert property (p_wr_lat)
      else $error("write answer late");
   property p_rd_lat; axil_req.arvalid && axil_rsp.arready
      |=> axil_rsp.rvalid; endproperty
   a_rd_lat: assert property (p_rd_lat)
      else $error("read answer late");
   property p_b_hold; axil_rsp.bvalid && !axil_req.bready
      |=> axil_rsp.bvalid && $stable(axil_rsp.bresp); endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped");
endmodule // lcdx_decoder_props

bind lcdx_decoder lcdx_decoder_props #(.BUSY_CYCLES(BUSY_CYCLES)) i_props (
   .aclk(aclk), .aresetn(aresetn), .axil_req(axil_req),
   .axil_rsp(axil_rsp), .busy_flag(busy_flag), .standby(standby),
   .ins_set_sel(ins_set_sel), .scroll_en(scroll_en),
   .line_reverse(line_reverse), .pix_wr(pix_wr));
`default_nettype wire

// ---- tb/test_lcdx_decoder.sv ----
// test_lcdx_decoder: self-checking bench for the extended decoder.
// assumes: host model drives the register bus; short busy count.
`timescale 1ns/1ps
`default_nettype none
module test_lcdx_decoder;
   import lcdx_pkg::*;
   localparam int unsigned BC = 8;
   logic aclk, aresetn, busy, stby, bw, ext, gfx, sen, pw;
   logic [5:0] sa, ga;
   logic [3:0] rev;
   logic [9:0] pa;
   logic [15:0] pd;
   logic [31:0] q;
   logic [1:0] r;
   logic [25:0] pix_q[$];
   lcdx_axil_req_t req;
   lcdx_axil_rsp_t rsp;
   int n_mismatch = 0, checks = 0, cyc = 0;

   lcdx_host i_host (.aclk(aclk), .req(req), .rsp(rsp));
   lcdx_decoder #(.BUSY_CYCLES(BC)) i_dut (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .axil_req      (req),
      .axil_rsp      (rsp),
      .busy_flag     (busy),
      .standby       (stby),
      .bus_width_sel (bw),
      .ins_set_sel   (ext),
      .graphics_on   (gfx),
      .scroll_en     (sen),
      .scroll_addr   (sa),
      .glyph_addr    (ga),
      .line_reverse  (rev),
      .pix_wr        (pw),
      .pix_addr      (pa),
      .pix_data      (pd)
   );

   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   always @(posedge aclk) if (pw === 1'b1) pix_q.push_back({pa, pd});
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         results();
      end
   end

   task automatic chk(input string n, input logic [31:0] s, e);
      checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic t_modes();
      logic [3:0] e;
      e = 4'h0;
      chk("reset", {rev, bw, ext, gfx, sen, stby}, 32'h0000_0010);
      i_host.cmd(9'h020);
      chk("bus_width", bw, 1'b0);
      i_host.cmd(9'h030);
      i_host.cmd(9'h034);
      chk("ext_set", {bw, ext}, 2'h3);
      i_host.cmd(9'h036);
      chk("gfx_on", gfx, 1'b1);
      i_host.cmd(9'h034);
      chk("gfx_off", gfx, 1'b0);
      for (int i = 0; i < 9; i++) begin
         i_host.cmd(9'h004 | 9'(i % 4));
         e[i % 4] = ~e[i % 4];
         chk("rev", rev, e);
      end
      i_host.cmd(9'h001);
      chk("stby", stby, 1'b1);
      i_host.cmd(9'h003);
      chk("stby_exit", {stby, sen}, 2'h1);
      i_host.cmd(9'h06A);
      chk("scroll", sa, 6'h2A);
      i_host.cmd(9'h002);
      i_host.cmd(9'h055);
      chk("glyph", {sen, sa, ga}, 13'h0A95);
      $display("test modes done");
   endtask

   task automatic t_gfx();
      pix_q.delete();
      i_host.cmd(9'h0A1);
      i_host.cmd(9'h0BE);
      for (int i = 0; i < 3; i++) begin
         i_host.cmd(9'h100 | 9'(i));
         i_host.cmd(9'h1A5);
      end
      chk("pix_count", pix_q.size(), 3);
      for (int i = 0; i < 3; i++)
         chk("pix", pix_q[i], {6'h21, 4'(4'hE + i), 8'(i), 8'hA5});
      i_host.cmd(9'h030);
      i_host.cmd(9'h004);
      chk("basic_rev", rev, 4'h1);
      $display("test graphics done");
   endtask

   task automatic t_bus();
      i_host.xfer(1'b1, 8'h10, '0, q, r);
      chk("wr_unmapped", r, RESP_SLVERR);
      i_host.xfer(1'b0, 8'h10, '0, q, r);
      chk("rd_unmapped", r, RESP_SLVERR);
      i_host.xfer(1'b1, REG_CMD, 32'h0000_0020, q, r);
      chk("busy", busy, 1'b1);
      i_host.xfer(1'b1, REG_CMD, 32'h0000_0030, q, r);
      i_host.xfer(1'b0, REG_STATUS, '0, q, r);
      chk("dropped", {bw, q[ST_DROP_BIT]}, 2'h1);
      i_host.cmd(9'h030);
      chk("bw_back", bw, 1'b1);
      $display("test bus done");
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      aresetn = 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      t_modes();
      t_gfx();
      t_bus();
      results();
   end
endmodule // test_lcdx_decoder
`default_nettype wire
